/* design/hrlp_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hrlp_regs.svh"
module hrlp_top
	import hrlp_pkg::*;
#(
	parameter int POR_CYC      = `HRLP_POR_CYC,
	parameter int L2_ENTRY_CYC = `HRLP_L2_ENTRY_CYC,
	parameter int L2_EXIT_CYC  = `HRLP_L2_EXIT_CYC
) (
	// clock and power-up reset
	input  wire logic       REF_CLK,
	input  wire logic       RST_N,
	// external reset pin
	input  wire logic       EXT_RESET_N,
	// upstream link events (pins)
	input  wire logic       BUS_RESET,
	input  wire logic       L1_REQ,
	input  wire logic       SUSPEND_IDLE,
	input  wire logic       RESUME,
	// enumeration updates from device logic
	input  wire logic       SET_ADDR,
	input  wire logic [6:0] ADDR_IN,
	input  wire logic       SET_CFG,
	input  wire logic [7:0] CFG_IN,
	// chip-level controls
	output var  logic       CHIP_RESET_N,
	output var  logic       STANDBY,
	output var  logic       PHY_EN,
	output var  logic       PAIRS_HIZ,
	output var  logic       XTAL_EN,
	output var  logic       PLL_EN,
	output var  logic       XFER_ABORT,
	output var  logic       DN_RESET,
	// usb device state
	output var  logic [1:0] LINK_STATE,
	output var  logic [6:0] DEV_ADDR,
	output var  logic [7:0] DEV_CFG,
	output var  logic       CONFIGURED
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [4:0] pin_s;
	logic       ext_rst_s;
	logic       bus_rst_s;
	logic       l1_s;
	logic       susp_s;
	logic       resume_s;

	hrlp_sync #(.W(5)) i_hrlp_sync (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.d     ({~EXT_RESET_N, BUS_RESET, L1_REQ, SUSPEND_IDLE, RESUME}),
		.q     (pin_s)
	);
	// inverted pin so reset-state of sync reads as pin asserted-free
	assign {ext_rst_s, bus_rst_s, l1_s, susp_s, resume_s} = pin_s;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] por_cnt;
		logic        por_done;
		logic        chip_rst_n;
		logic        standby;
		logic        abort;
		logic        dn_reset;
		logic        phy_en;
		logic        xtal_en;
		logic        pll_en;
		logic        configured;
		hrlp_state_e st;
		logic [31:0] cnt;
		logic [1:0]  link;
		logic [6:0]  addr;
		logic [7:0]  cfg;
	} hrlp_core_s;

	hrlp_core_s cur_r;
	hrlp_core_s cur_nxt;

	function automatic logic [31:0] hrlp_step(input logic [31:0] c);
		return c + 32'h0000_0001;
	endfunction

	always_comb begin
		cur_nxt          = cur_r;
		cur_nxt.abort    = 1'b0;
		cur_nxt.dn_reset = 1'b0;
		// power-up timer: internal reset held for a fixed interval
		if (!cur_r.por_done) begin
			cur_nxt.por_cnt = hrlp_step(cur_r.por_cnt);
			if (cur_r.por_cnt >= 32'(POR_CYC - 1)) begin
				cur_nxt.por_done = 1'b1;
			end
		end
		// pin reset and power-up merged into one chip reset
		cur_nxt.chip_rst_n = cur_r.por_done && !ext_rst_s;
		cur_nxt.standby    = ext_rst_s;
		if (ext_rst_s) begin
			// abort raised; everything else but the power-up timer goes back to defaults
			cur_nxt.abort = 1'b1;
			cur_nxt.st    = HRLP_ON;
			cur_nxt.cnt   = '0;
			cur_nxt.link  = HRLP_L0;
			cur_nxt.addr  = `HRLP_ADDR_DEFAULT;
			cur_nxt.cfg   = `HRLP_CFG_DEFAULT;
		end else if (!cur_r.chip_rst_n) begin
			cur_nxt.st   = HRLP_ON;
			cur_nxt.cnt  = '0;
			cur_nxt.link = HRLP_L0;
		end else if (bus_rst_s) begin
			// usb state only; clocks keep running
			cur_nxt.addr = `HRLP_ADDR_DEFAULT;
			cur_nxt.cfg  = `HRLP_CFG_DEFAULT;
			cur_nxt.st   = HRLP_ON;
			cur_nxt.link = HRLP_L0;
			cur_nxt.cnt  = '0;
		end else begin
			if (SET_ADDR) begin
				cur_nxt.addr = ADDR_IN;
			end
			if (SET_CFG) begin
				cur_nxt.cfg = CFG_IN;
			end
			cur_nxt.cnt = hrlp_step(cur_r.cnt);
			case (cur_r.st)
				HRLP_ON: begin
					cur_nxt.cnt = '0;
					if (l1_s) begin
						cur_nxt.st = HRLP_L1_ENTER;
					end else if (susp_s) begin
						cur_nxt.st = HRLP_L2_ENTER;
					end
				end
				HRLP_L1_ENTER: begin
					if (cur_r.cnt >= 32'(`HRLP_L1_ENTRY_CYC - `HRLP_SYNC_CYC - 1)) begin
						cur_nxt.st   = HRLP_SLEEP;
						cur_nxt.link = HRLP_L1;
						cur_nxt.cnt  = '0;
					end
				end
				HRLP_SLEEP: begin
					cur_nxt.cnt = '0;
					if (!l1_s || resume_s) begin
						cur_nxt.st = HRLP_L1_EXIT;
					end
				end
				HRLP_L1_EXIT: begin
					if (cur_r.cnt >= 32'(`HRLP_L1_EXIT_CYC - `HRLP_SYNC_CYC - 1)) begin
						cur_nxt.st   = HRLP_ON;
						cur_nxt.link = HRLP_L0;
						cur_nxt.cnt  = '0;
					end
				end
				HRLP_L2_ENTER: begin
					// idle must persist for the whole entry window
					if (!susp_s) begin
						cur_nxt.st  = HRLP_ON;
						cur_nxt.cnt = '0;
					end else if (cur_r.cnt >= 32'(L2_ENTRY_CYC - `HRLP_SYNC_CYC - 1)) begin
						cur_nxt.st   = HRLP_SUSP;
						cur_nxt.link = HRLP_L2;
						cur_nxt.cnt  = '0;
					end
				end
				HRLP_SUSP: begin
					cur_nxt.cnt = '0;
					if (resume_s) begin
						cur_nxt.st = HRLP_L2_EXIT;
					end
				end
				HRLP_L2_EXIT: begin
					if (cur_r.cnt >= 32'(L2_EXIT_CYC - `HRLP_SYNC_CYC - 1)) begin
						cur_nxt.st   = HRLP_ON;
						cur_nxt.link = HRLP_L0;
						cur_nxt.cnt  = '0;
					end
				end
				default: begin
					cur_nxt.st  = HRLP_ON;
					cur_nxt.cnt = '0;
				end
			endcase
		end
		// taken from the next state so these move in step with standby
		cur_nxt.phy_en     = !cur_nxt.standby && cur_nxt.chip_rst_n;
		cur_nxt.xtal_en    = !cur_nxt.standby;
		cur_nxt.pll_en     = !cur_nxt.standby;
		cur_nxt.configured = (cur_nxt.cfg != `HRLP_CFG_DEFAULT);
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cur_r <= '{por_cnt: '0, por_done: 1'b0, chip_rst_n: 1'b0, standby: 1'b0,
				abort: 1'b0, dn_reset: 1'b0, phy_en: 1'b0, xtal_en: 1'b1, pll_en: 1'b1,
				configured: 1'b0, st: HRLP_ON, cnt: '0, link: HRLP_L0,
				addr: `HRLP_ADDR_DEFAULT, cfg: `HRLP_CFG_DEFAULT};
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// ----------------------------------------
	// outputs, all from flip-flops
	// ----------------------------------------
	assign CHIP_RESET_N = cur_r.chip_rst_n;
	assign STANDBY      = cur_r.standby;
	assign PHY_EN       = cur_r.phy_en;
	assign PAIRS_HIZ    = cur_r.standby;
	// clocks restart only once the pin lets go
	assign XTAL_EN      = cur_r.xtal_en;
	assign PLL_EN       = cur_r.pll_en;
	assign XFER_ABORT   = cur_r.abort;
	assign DN_RESET     = cur_r.dn_reset;
	assign LINK_STATE   = cur_r.link;
	assign DEV_ADDR     = cur_r.addr;
	assign DEV_CFG      = cur_r.cfg;
	assign CONFIGURED   = cur_r.configured;
endmodule
`default_nettype wire

/* design/hrlp_regs.svh */
`ifndef HRLP_REGS_SVH
`define HRLP_REGS_SVH
// ----------------------------------------
// timing figures and counts at 10 MHz
// ----------------------------------------
`define HRLP_CLK_MHZ        10
`define HRLP_POR_US         1000
`define HRLP_L1_ENTRY_US    10
`define HRLP_L1_EXIT_US     50
`define HRLP_L2_ENTRY_US    3000
`define HRLP_L2_EXIT_US     2000
// two sync stages plus the decision edge, taken off every pin-driven count
`define HRLP_SYNC_CYC       3
// shortest times round down, never below one cycle
`define HRLP_L1_ENTRY_CYC   ((`HRLP_L1_ENTRY_US * `HRLP_CLK_MHZ) - 1)
`define HRLP_L1_EXIT_CYC    ((`HRLP_L1_EXIT_US * `HRLP_CLK_MHZ) - 1)
`define HRLP_L2_ENTRY_CYC   (`HRLP_L2_ENTRY_US * `HRLP_CLK_MHZ)
`define HRLP_L2_EXIT_CYC    (`HRLP_L2_EXIT_US * `HRLP_CLK_MHZ)
`define HRLP_POR_CYC        (`HRLP_POR_US * `HRLP_CLK_MHZ)
// ----------------------------------------
// reset values
// ----------------------------------------
`define HRLP_ADDR_DEFAULT   7'h00
`define HRLP_CFG_DEFAULT    8'h00
`endif

/* design/hrlp_pkg.sv */
package hrlp_pkg;
	typedef enum logic [1:0] {
		HRLP_L0,
		HRLP_L1,
		HRLP_L2
	} hrlp_link_e;
	typedef enum logic [2:0] {
		HRLP_ON,
		HRLP_L1_ENTER,
		HRLP_SLEEP,
		HRLP_L1_EXIT,
		HRLP_L2_ENTER,
		HRLP_SUSP,
		HRLP_L2_EXIT
	} hrlp_state_e;
endpackage

/* design/hrlp_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module hrlp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* tb/hrlp_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module hrlp_checker #(
	parameter int POR_CYC = 16
) (
	// clock and pins
	input	wire logic		REF_CLK,
	input	wire logic		RST_N,
	input	wire logic		EXT_RESET_N,
	input	wire logic		BUS_RESET,
	// chip controls
	input	wire logic		CHIP_RESET_N,
	input	wire logic		STANDBY,
	input	wire logic		PHY_EN,
	input	wire logic		PAIRS_HIZ,
	input	wire logic		XTAL_EN,
	input	wire logic		PLL_EN,
	input	wire logic		XFER_ABORT,
	input	wire logic		DN_RESET,
	// device state
	input	wire logic [1:0]	LINK_STATE,
	input	wire logic [6:0]	DEV_ADDR,
	input	wire logic [7:0]	DEV_CFG
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	int	cyc_r;
	// saturates so a long run never wraps
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cyc_r <= 0;
		end else if (cyc_r < 4000) begin
			cyc_r <= cyc_r + 1;
		end
	end
	AST_POR_HOLD: assert property (cyc_r < POR_CYC |-> !CHIP_RESET_N) else $error("chip reset early");
	AST_DN_NEVER: assert property (DN_RESET == 1'h0) else $error("bus reset forwarded");
	AST_PHY_FLOAT: assert property (PAIRS_HIZ |-> !PHY_EN) else $error("phy on while floating");
	AST_PIN_STBY: assert property (!EXT_RESET_N [*5] |-> STANDBY && PAIRS_HIZ) else $error("no standby");
	AST_PIN_CLK: assert property (!EXT_RESET_N [*5] |-> !XTAL_EN && !PLL_EN) else $error("clocks run");
	AST_PIN_ABORT: assert property (!EXT_RESET_N [*5] |-> XFER_ABORT && !CHIP_RESET_N) else $error("no abort");
	AST_PIN_DEF: assert property (STANDBY |-> DEV_ADDR == 7'h00 && DEV_CFG == 8'h00) else $error("state kept");
	AST_BUS_CLR: assert property (BUS_RESET [*5] |-> DEV_ADDR == 7'h00 && DEV_CFG == 8'h00 && LINK_STATE == 2'h0)
		else $error("bus reset left state");
	AST_BUS_CLK: assert property ((BUS_RESET && EXT_RESET_N) [*5] |-> XTAL_EN && PLL_EN) else $error("clocks hit");
	cover property (STANDBY);
	cover property (LINK_STATE == 2'h1);
	cover property (LINK_STATE == 2'h2);
endmodule
bind hrlp_top hrlp_checker #(.POR_CYC(POR_CYC)) i_hrlp_checker (.*);
`default_nettype wire

/* tb/hrlp_host.sv */
`timescale 1ns/1ns
`default_nettype none
module hrlp_host (
	// requests from the scenarios
	input	wire logic [4:0]	want_pins,
	input	wire logic		want_enum,
	input	wire logic [6:0]	want_addr,
	input	wire logic [7:0]	want_cfg,
	// upstream pins and enumeration strobes
	output	var logic		ext_reset_n,
	output	var logic		bus_reset,
	output	var logic		l1_req,
	output	var logic		suspend_idle,
	output	var logic		resume,
	output	var logic		set_addr,
	output	var logic [6:0]	addr,
	output	var logic		set_cfg,
	output	var logic [7:0]	cfg
);
	// supplies good from time zero, so the pin may be asserted at any time
	always_comb begin
		{ext_reset_n, bus_reset, l1_req, suspend_idle, resume} = want_pins;
		set_addr = want_enum;
		set_cfg  = want_enum;
		// host configures again after a bus reset; data turned over once stale
		addr     = want_enum ? want_addr : ~want_addr;
		cfg      = want_enum ? want_cfg : ~want_cfg;
	end
endmodule
`default_nettype wire

/* tb/test_hub_reset_and_link_power.sv */
`timescale 1ns/1ns
`default_nettype none
module test_hub_reset_and_link_power;
	import hrlp_pkg::*;
	localparam int	POR = 16;
	localparam int	L2C = 20;
	logic			ref_clk = 1'h0;
	logic			rst_n = 1'h0;
	// requests handed to the host model
	logic [4:0]		want_pins = 5'h10;
	logic			want_enum = 1'h0;
	logic [6:0]		want_addr = 7'h00;
	logic [7:0]		want_cfg = 8'h00;
	int			fail_count = 0;
	int			total_checks = 0;
	int			n;
	wire logic		ern, br, l1, si, rs, sa, sc, crn, stb, phy, hiz, xt, pll, abt, dn, conf;
	wire logic [1:0]	link;
	wire logic [6:0]	ai, addr;
	wire logic [7:0]	ci, cfg;
	hrlp_host i_hrlp_host (.want_pins(want_pins), .want_enum(want_enum), .want_addr(want_addr),
		.want_cfg(want_cfg), .ext_reset_n(ern), .bus_reset(br), .l1_req(l1), .suspend_idle(si),
		.resume(rs), .set_addr(sa), .addr(ai), .set_cfg(sc), .cfg(ci));
	hrlp_top #(.POR_CYC(POR), .L2_ENTRY_CYC(L2C), .L2_EXIT_CYC(L2C)) i_hrlp_top (.REF_CLK(ref_clk), .RST_N(rst_n),
		.EXT_RESET_N(ern), .BUS_RESET(br), .L1_REQ(l1), .SUSPEND_IDLE(si), .RESUME(rs), .SET_ADDR(sa),
		.ADDR_IN(ai), .SET_CFG(sc), .CFG_IN(ci), .CHIP_RESET_N(crn), .STANDBY(stb), .PHY_EN(phy),
		.PAIRS_HIZ(hiz), .XTAL_EN(xt), .PLL_EN(pll), .XFER_ABORT(abt), .DN_RESET(dn), .LINK_STATE(link),
		.DEV_ADDR(addr), .DEV_CFG(cfg), .CONFIGURED(conf));
	always #50 ref_clk = ~ref_clk;
	task tick(input int k);
		repeat (k) @(posedge ref_clk);
		#2;
	endtask
	task pins(input logic [4:0] v);
		@(posedge ref_clk) #1 want_pins = v;
	endtask
	task enumerate(input logic [6:0] a, input logic [7:0] c);
		@(posedge ref_clk) #1 {want_enum, want_addr, want_cfg} = {1'h1, a, c};
		@(posedge ref_clk) #1 want_enum = 1'h0;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task give_verdict();
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// bounded wait; n counts edges from the pin change, sync stages included
	task wait_link(input logic [1:0] v, input int lim);
		n = 0;
		while (link !== v && n < lim) begin
			tick(1);
			n++;
		end
		if (link !== v) begin
			fail_count++;
			give_verdict();
		end
	endtask
	task t_por();
		check(crn, 1'h0);
		n = 0;
		while (crn !== 1'h1 && n < 40) begin
			tick(1);
			n++;
		end
		check(n >= POR && n < POR + 4, 1'h1);
		check({xt, pll, dn}, 3'h6);
	endtask
	task t_l1();
		pins(5'h14);
		wait_link(HRLP_L1, 110);
		check(n < 100, 1'h1);
		pins(5'h10);
		wait_link(HRLP_L0, 510);
		check(n < 500, 1'h1);
	endtask
	task t_l2();
		pins(5'h12);
		tick(L2C / 2);
		pins(5'h10);
		tick(L2C + 5);
		check(link, HRLP_L0);
		pins(5'h12);
		wait_link(HRLP_L2, L2C + 9);
		check(n >= L2C - 3, 1'h1);
		pins(5'h11);
		wait_link(HRLP_L0, L2C + 9);
		check(n >= L2C, 1'h1);
		pins(5'h10);
	endtask
	task t_bus();
		enumerate(7'h55, 8'h01);
		check({addr, conf}, 8'hab);
		pins(5'h12);
		wait_link(HRLP_L2, L2C + 9);
		pins(5'h18);
		wait_link(HRLP_L0, 6);
		enumerate(7'h22, 8'h02);
		check({cfg, conf, dn}, 10'h0);
		check({addr, xt, pll, crn}, 10'h7);
		pins(5'h10);
	endtask
	task t_pin();
		enumerate(7'h33, 8'h04);
		check(addr, 7'h33);
		pins(5'h00);
		tick(5);
		check({stb, phy, hiz, abt, crn}, 5'h16);
		check({addr, cfg, link}, 17'h0);
		check({xt, pll}, 2'h0);
		pins(5'h10);
		tick(5);
		check({stb, hiz, xt, pll, crn, phy, abt}, 7'h1e);
	endtask
	// power removed and reapplied mid-run
	task t_repower();
		enumerate(7'h11, 8'h08);
		check(cfg, 8'h08);
		@(posedge ref_clk) #1 rst_n = 1'h0;
		repeat (3) @(posedge ref_clk);
		#1 rst_n = 1'h1;
		t_por();
		check({addr, cfg, link, conf}, 18'h0);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		#1 rst_n = 1'h1;
		t_por();
		t_l1();
		t_l2();
		tick(5);
		t_bus();
		tick(5);
		t_pin();
		t_repower();
		give_verdict();
	end
endmodule
`default_nettype wire
